// >>> src/fcl_pkg.sv
// Package for the fully closed-loop feedback block: register indices,
// reset values, field widths and carrier types.
// Assumes a 32-bit AHB-Lite register bus; byte address = 4 * index.
package fcl_pkg;

	// ----------------------------------------
	// Register indices
	// ----------------------------------------
	localparam logic [13:0] RI_FB_SRC = 14'h0f00;
	localparam logic [13:0] RI_EXT_DIR = 14'h0f01;
	localparam logic [13:0] RI_EXT_KIND = 14'h0f02;
	localparam logic [13:0] RI_SIG_TYPE = 14'h0f03;
	localparam logic [13:0] RI_PPR = 14'h0f04;
	localparam logic [13:0] RI_DEV_THR = 14'h0f08;
	localparam logic [13:0] RI_CLR_REVS = 14'h0f0a;
	localparam logic [13:0] RI_FILT_TIME = 14'h0f0d;
	localparam logic [13:0] RI_DEV_DISP = 14'h0f10;
	localparam logic [13:0] RI_INT_CNT = 14'h0f12;
	localparam logic [13:0] RI_EXT_CNT = 14'h0f14;
	localparam logic [13:0] RI_IDX_OFF = 14'h0f16;
	localparam logic [13:0] RI_PROBE_SRC = 14'h0f19;
	localparam logic [13:0] RI_THR_SCALE = 14'h0f2d;
	localparam logic [13:0] RI_SPD_SRC = 14'h0f2e;

	// ----------------------------------------
	// Reset values and field encodings
	// ----------------------------------------
	localparam logic [31:0] RST_PPR = 32'h0000_2710;
	localparam logic [31:0] RST_DEV_THR = 32'h0000_03e8;
	localparam logic [6:0] RST_CLR_REVS = 7'h01;
	localparam logic [6:0] MAX_CLR_REVS = 7'h64;
	localparam logic [1:0] FB_INTERNAL = 2'h0;
	localparam logic [1:0] FB_EXTERNAL = 2'h1;
	localparam logic [1:0] FB_SWITCHOVER = 2'h2;
	localparam logic [1:0] FB_MAX = 2'h2;

	// Motor encoder resolution is a power of two so conversion is a shift
	localparam int MOTOR_RES_LOG2 = 17;
	localparam int FIX_W = 32 + MOTOR_RES_LOG2;
	localparam int REV_W = 7 + MOTOR_RES_LOG2;

	// ----------------------------------------
	// Carrier types
	// ----------------------------------------
	typedef struct packed {
		logic a;
		logic b;
		logic z;
	} fcl_enc_pins_t;

	typedef struct packed {
		logic fault;
		logic use_external;
		logic gear_ratio2;
		logic speed_external;
		logic ext_absolute;
		logic filter_active;
		logic thr_shared;
		logic probe_index;
	} fcl_status_t;

endpackage

// >>> src/fcl_quad_decoder.sv
// Quadrature decoder: synchronises A/B/Z pins and gives a x4 step and
// a rising-edge pulse on Z.
// Assumes pins are asynchronous to clk_in; one edge per clock at most.
`timescale 1ns/100ps
module fcl_quad_decoder
	import fcl_pkg::*;
(
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire fcl_pkg::fcl_enc_pins_t pins_in,
	input wire logic reverse_in,
	output logic step_up_out,
	output logic step_dn_out,
	output logic z_rise_out
);
	fcl_enc_pins_t sync1;
	fcl_enc_pins_t sync2;
	fcl_enc_pins_t prev;
	wire fwd;
	wire bwd;

	always_ff @(posedge clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			sync1 <= '0;
			sync2 <= '0;
			prev <= '0;
		end
		else
		begin
			sync1 <= pins_in;
			sync2 <= sync1;
			prev <= sync2;
		end
	end

	// A leads B counts up unless reverse_in is set; any illegal double change is dropped
	assign fwd = (sync2.a ^ prev.b) & ~(sync2.b ^ prev.a);
	assign bwd = (sync2.b ^ prev.a) & ~(sync2.a ^ prev.b);
	assign step_up_out = reverse_in ? bwd : fwd;
	assign step_dn_out = reverse_in ? fwd : bwd;
	assign z_rise_out = sync2.z & ~prev.z;

endmodule

// >>> src/fcl_feedback.sv
// Fully closed-loop position feedback: source selection, pulse counters,
// inner/outer deviation, excessive-deviation fault, AHB-Lite registers.
// Assumes one clock, encoder and gear-select pins asynchronous,
// run and fault-reset strobes from logic on clk_in.
//
// Summary of operation
// - Feedback source 0 motor encoder, 1 external, 2 switched by input.
// - Fixed external feedback uses the first gear ratio.
// - Switchover: inactive input internal/ratio one, active external/ratio two.
// - External count direction 0 same as internal, 1 opposite.
// - External encoder kind 0 incremental, 1 absolute linear scale.
// - Unsigned 31-bit external pulses per motor turn, default 10000, scales counts.
// - Fault when loop deviation exceeds unsigned threshold, default 1000.
// - Zero threshold: no fault detection, deviation held cleared.
// - Running: clear deviation every configured revolutions, 0 to 100, default 1.
// - Revolution progress held while the drive is not running.
// - Vibration filter time applies only with external or switchover feedback.
// - Deviation is external position minus converted internal position.
// - Read-only signed count of internal feedback pulses.
// - Read-only signed count of external feedback pulses.
// - External Z checked when setting 0, ignored when 1.
// - Probe index from motor Z on 0, external Z on 1.
// - Threshold scaling 0 to outer-loop units, 1 shared threshold.
// - Speed feedback from internal encoder on 0, external on 1.
// - External feedback type accepts only quadrature, value 0.
//
// The AHB-Lite interface to the registers is this design's own decision.
`timescale 1ns/100ps
module fcl_feedback
	import fcl_pkg::*;
(
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic hsel_in,
	input wire logic [31:0] haddr_in,
	input wire logic [1:0] htrans_in,
	input wire logic hwrite_in,
	input wire logic [2:0] hsize_in,
	input wire logic [31:0] hwdata_in,
	input wire logic hready_in,
	output logic [31:0] hrdata_out,
	output logic hreadyout_out,
	output logic hresp_out,
	input wire fcl_pkg::fcl_enc_pins_t motor_enc_in,
	input wire fcl_pkg::fcl_enc_pins_t ext_enc_in,
	input wire logic gear_select_in,
	input wire logic drive_running_in,
	input wire logic fault_reset_in,
	output fcl_pkg::fcl_status_t status_out,
	output logic [31:0] position_feedback_out,
	output logic [15:0] filter_time_out
);
	import fcl_pkg::*;

	// ----------------------------------------
	// Configuration registers
	// ----------------------------------------
	logic [1:0] feedback_source_select;
	logic external_count_direction;
	logic external_encoder_kind;
	logic [31:0] external_pulses_per_rev;
	logic [31:0] deviation_fault_threshold;
	logic [6:0] deviation_clear_revolutions;
	logic [15:0] vibration_filter_time;
	logic external_index_check_off;
	logic probe_index_source;
	logic completion_threshold_scaling;
	logic speed_feedback_source;

	// ----------------------------------------
	// Bus state
	// ----------------------------------------
	logic wr_pend;
	logic [13:0] wr_idx;
	wire take;
	wire [13:0] rd_idx;
	wire wr_hit;
	logic [31:0] rd_mux;

	// ----------------------------------------
	// Feedback state
	// ----------------------------------------
	logic gsel_s1;
	logic gsel_s2;
	logic signed [31:0] internal_pulse_count;
	logic signed [31:0] external_pulse_count;
	logic [FIX_W-1:0] conv_fix;
	logic [REV_W-1:0] rev_progress;
	logic signed [31:0] loop_deviation_display;
	logic excessive_loop_deviation_fault;
	wire m_up;
	wire m_dn;
	wire m_z;
	wire e_up;
	wire e_dn;
	wire e_z;
	wire use_ext;
	wire gear2;
	wire signed [31:0] next_external_pulse_count;
	wire signed [31:0] deviation;
	wire [32:0] dev_mag;
	wire [REV_W-1:0] rev_target;
	wire rev_done;
	wire dev_clear;
	wire dev_over;
	wire ext_z_ok;
	wire next_probe;

	// ----------------------------------------
	// Encoder decoders
	// ----------------------------------------
	fcl_quad_decoder u_motor_dec (
		.clk_in(clk_in),
		.sys_rst_in(sys_rst_in),
		.pins_in(motor_enc_in),
		.reverse_in(1'b0),
		.step_up_out(m_up),
		.step_dn_out(m_dn),
		.z_rise_out(m_z)
	);

	fcl_quad_decoder u_ext_dec (
		.clk_in(clk_in),
		.sys_rst_in(sys_rst_in),
		.pins_in(ext_enc_in),
		.reverse_in(external_count_direction),
		.step_up_out(e_up),
		.step_dn_out(e_dn),
		.z_rise_out(e_z)
	);

	// ----------------------------------------
	// Source selection
	// ----------------------------------------
	assign use_ext = (feedback_source_select == FB_EXTERNAL)
		| ((feedback_source_select == FB_SWITCHOVER) & gsel_s2);
	assign gear2 = (feedback_source_select == FB_SWITCHOVER) & gsel_s2;
	// Absolute scales carry no index, so their Z is never used
	assign ext_z_ok = e_z & ~external_index_check_off & ~external_encoder_kind;
	assign next_probe = probe_index_source ? ext_z_ok : m_z;

	// ----------------------------------------
	// Deviation arithmetic
	// ----------------------------------------
	assign next_external_pulse_count = external_pulse_count
		+ {{31{e_dn}}, e_up | e_dn};
	// Internal position is carried in external units with a binary fraction
	assign deviation = external_pulse_count
		- $signed(conv_fix[FIX_W-1:MOTOR_RES_LOG2]);
	assign dev_mag = deviation[31] ? 33'(-{deviation[31], deviation})
		: {1'b0, deviation};
	assign dev_over = (deviation_fault_threshold != 32'h0000_0000)
		& (dev_mag > {1'b0, deviation_fault_threshold});
	assign rev_target = {deviation_clear_revolutions, {MOTOR_RES_LOG2{1'b0}}};
	assign rev_done = drive_running_in & (deviation_clear_revolutions != 7'h00)
		& (m_up | m_dn) & (rev_progress + 1'b1 >= rev_target);
	assign dev_clear = (deviation_fault_threshold == 32'h0000_0000) | rev_done;

	always_ff @(posedge clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
			gsel_s1 <= 1'b0;
		else
			gsel_s1 <= gear_select_in;
	end

	always_ff @(posedge clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
			gsel_s2 <= 1'b0;
		else
			gsel_s2 <= gsel_s1;
	end

	always_ff @(posedge clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			internal_pulse_count <= '0;
			external_pulse_count <= '0;
		end
		else
		begin
			internal_pulse_count <= internal_pulse_count + {{31{m_dn}}, m_up | m_dn};
			external_pulse_count <= next_external_pulse_count;
		end
	end

	always_ff @(posedge clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
			conv_fix <= '0;
		else if (dev_clear)
			conv_fix <= {next_external_pulse_count, {MOTOR_RES_LOG2{1'b0}}};
		else if (m_up)
			conv_fix <= conv_fix + FIX_W'(external_pulses_per_rev);
		else if (m_dn)
			conv_fix <= conv_fix - FIX_W'(external_pulses_per_rev);
	end

	// Progress counts motor pulses in either direction; frozen when stopped
	always_ff @(posedge clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
			rev_progress <= '0;
		else if (rev_done)
			rev_progress <= '0;
		else if (drive_running_in & (m_up | m_dn))
			rev_progress <= rev_progress + 1'b1;
	end

	always_ff @(posedge clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
			loop_deviation_display <= '0;
		else
			loop_deviation_display <= dev_clear ? 32'sh0000_0000 : deviation;
	end

	// Set wins over a reset request arriving in the same cycle
	always_ff @(posedge clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
			excessive_loop_deviation_fault <= 1'b0;
		else if (drive_running_in & dev_over & ~dev_clear)
			excessive_loop_deviation_fault <= 1'b1;
		else if (fault_reset_in & ~drive_running_in)
			excessive_loop_deviation_fault <= 1'b0;
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	always_ff @(posedge clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			status_out <= '0;
			position_feedback_out <= '0;
			filter_time_out <= '0;
		end
		else
		begin
			status_out.fault <= excessive_loop_deviation_fault;
			status_out.use_external <= use_ext;
			status_out.gear_ratio2 <= gear2;
			status_out.speed_external <= speed_feedback_source;
			status_out.ext_absolute <= external_encoder_kind;
			status_out.filter_active <= feedback_source_select != FB_INTERNAL;
			status_out.thr_shared <= completion_threshold_scaling;
			status_out.probe_index <= next_probe;
			position_feedback_out <= use_ext ? external_pulse_count
				: internal_pulse_count;
			filter_time_out <= (feedback_source_select != FB_INTERNAL)
				? vibration_filter_time : 16'h0000;
		end
	end

	// ----------------------------------------
	// AHB-Lite slave, zero wait states
	// ----------------------------------------
	assign take = hsel_in & hready_in & htrans_in[1];
	assign rd_idx = haddr_in[15:2];
	// A read right behind a write to the same word sees the new data
	assign wr_hit = wr_pend & (wr_idx == rd_idx);

	always_comb
	begin
		rd_mux = 32'h0000_0000;
		unique case (rd_idx)
			RI_FB_SRC: rd_mux[1:0] = feedback_source_select;
			RI_EXT_DIR: rd_mux[0] = external_count_direction;
			RI_EXT_KIND: rd_mux[0] = external_encoder_kind;
			RI_SIG_TYPE: rd_mux = 32'h0000_0000;
			RI_PPR: rd_mux = external_pulses_per_rev;
			RI_DEV_THR: rd_mux = deviation_fault_threshold;
			RI_CLR_REVS: rd_mux[6:0] = deviation_clear_revolutions;
			RI_FILT_TIME: rd_mux[15:0] = vibration_filter_time;
			RI_DEV_DISP: rd_mux = loop_deviation_display;
			RI_INT_CNT: rd_mux = internal_pulse_count;
			RI_EXT_CNT: rd_mux = external_pulse_count;
			RI_IDX_OFF: rd_mux[0] = external_index_check_off;
			RI_PROBE_SRC: rd_mux[0] = probe_index_source;
			RI_THR_SCALE: rd_mux[0] = completion_threshold_scaling;
			RI_SPD_SRC: rd_mux[0] = speed_feedback_source;
			default: rd_mux = 32'h0000_0000;
		endcase
		if (wr_hit & (rd_idx != RI_SIG_TYPE))
			rd_mux = hwdata_in;
	end

	always_ff @(posedge clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			wr_pend <= 1'b0;
			wr_idx <= '0;
			hrdata_out <= '0;
			hreadyout_out <= 1'b1;
			hresp_out <= 1'b0;
		end
		else
		begin
			wr_pend <= take & hwrite_in;
			wr_idx <= rd_idx;
			if (take & ~hwrite_in)
				hrdata_out <= rd_mux;
			hreadyout_out <= 1'b1;
			hresp_out <= 1'b0;
		end
	end

	// Out-of-range codes are refused so the stored mode is always legal
	always_ff @(posedge clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			feedback_source_select <= FB_INTERNAL;
			external_count_direction <= 1'b0;
			external_encoder_kind <= 1'b0;
			external_pulses_per_rev <= RST_PPR;
			deviation_fault_threshold <= RST_DEV_THR;
			deviation_clear_revolutions <= RST_CLR_REVS;
			vibration_filter_time <= '0;
			external_index_check_off <= 1'b0;
			probe_index_source <= 1'b0;
			completion_threshold_scaling <= 1'b0;
			speed_feedback_source <= 1'b0;
		end
		else if (wr_pend)
		begin
			unique case (wr_idx)
				RI_FB_SRC:
					if (hwdata_in[15:0] <= {14'h0000, FB_MAX})
						feedback_source_select <= hwdata_in[1:0];
				RI_EXT_DIR: external_count_direction <= hwdata_in[0];
				RI_EXT_KIND: external_encoder_kind <= hwdata_in[0];
				RI_PPR:
					if (!hwdata_in[31])
						external_pulses_per_rev <= hwdata_in;
				RI_DEV_THR:
					if (!hwdata_in[31])
						deviation_fault_threshold <= hwdata_in;
				RI_CLR_REVS:
					if (hwdata_in[15:0] <= {9'h000, MAX_CLR_REVS})
						deviation_clear_revolutions <= hwdata_in[6:0];
				RI_FILT_TIME: vibration_filter_time <= hwdata_in[15:0];
				RI_IDX_OFF: external_index_check_off <= hwdata_in[0];
				RI_PROBE_SRC: probe_index_source <= hwdata_in[0];
				RI_THR_SCALE: completion_threshold_scaling <= hwdata_in[0];
				RI_SPD_SRC: speed_feedback_source <= hwdata_in[0];
				default: ;
			endcase
		end
	end

endmodule

// >>> sim/fcl_enc_model.sv
// Behavioural quadrature encoder: steps on request, one phase change every DIV clocks.
// Assumes requests come from the bench on the rising edge of clk_in.
`timescale 1ns/100ps
module fcl_enc_model
	import fcl_pkg::*;
#(
	parameter int DIV = 1
)
(
	input wire logic clk_in,
	input wire logic go_in,
	input wire logic rev_in,
	input wire logic [15:0] steps_in,
	input wire logic index_in,
	output fcl_pkg::fcl_enc_pins_t pins_out,
	output logic busy_out
);
	import fcl_pkg::*;
	logic [1:0] phase = 2'h0;
	logic [15:0] left = 16'h0000;
	int div_cnt = 0;
	assign busy_out = (left != 16'h0000);
	// Gray order 00,10,11,01: A leads B when moving forward
	assign pins_out.a = phase[1] ^ phase[0];
	assign pins_out.b = phase[1];
	assign pins_out.z = index_in;
	always @(posedge clk_in)
	begin
		if (go_in)
			left <= steps_in;
		else if (busy_out && div_cnt == DIV - 1)
		begin
			div_cnt <= 0;
			phase <= rev_in ? phase - 2'h1 : phase + 2'h1;
			left <= left - 16'h0001;
		end
		else if (busy_out)
			div_cnt <= div_cnt + 1;
	end
endmodule

// >>> sim/fcl_feedback_chk.sv
// Port checker for fcl_feedback: bus answer, status relations, fault latch.
// Assumes one clock domain; attached by the bind at the foot.
`timescale 1ns/100ps
module fcl_feedback_chk
	import fcl_pkg::*;
(
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic hsel_in,
	input wire logic [1:0] htrans_in,
	input wire logic hwrite_in,
	input wire logic hready_in,
	input wire logic [31:0] hrdata_out,
	input wire logic hreadyout_out,
	input wire logic hresp_out,
	input wire logic drive_running_in,
	input wire logic fault_reset_in,
	input wire fcl_pkg::fcl_status_t status_out,
	input wire logic [15:0] filter_time_out
);
	import fcl_pkg::*;
	wire logic rd_take = hsel_in && hready_in && htrans_in[1] && !hwrite_in;
	wire logic clr_ok = fault_reset_in && !drive_running_in;
	default clocking @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);
	bus_ready_a: assert property (hreadyout_out)
		else $error("bus not ready");
	bus_okay_a: assert property (!hresp_out)
		else $error("bus response not okay");
	rdata_hold_a: assert property (!$past(rd_take) |-> $stable(hrdata_out))
		else $error("read data moved without a read");
	fault_hold_a: assert property (status_out.fault && !clr_ok && !$past(clr_ok) |=> status_out.fault)
		else $error("fault dropped without reset");
	fault_cause_a: assert property ($rose(status_out.fault) |-> $past(drive_running_in) || $past(drive_running_in, 2))
		else $error("fault raised while stopped");
	fault_clear_a: assert property ($fell(status_out.fault) |-> $past(clr_ok) || $past(clr_ok, 2))
		else $error("fault cleared without stopped reset");
	gear_ext_a: assert property (status_out.gear_ratio2 |-> status_out.use_external)
		else $error("ratio two without external feedback");
	filt_gate_a: assert property (!status_out.filter_active |-> filter_time_out == 16'h0000)
		else $error("filter time passed with internal feedback");
	probe_pulse_a: assert property (status_out.probe_index |=> !status_out.probe_index)
		else $error("probe index longer than one cycle");
	fault_rise_c: cover property ($rose(status_out.fault));
	read_c: cover property (rd_take);
	probe_c: cover property (status_out.probe_index);
	ratio2_c: cover property (status_out.gear_ratio2);
endmodule
bind fcl_feedback fcl_feedback_chk i_fcl_feedback_chk (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
	.hsel_in(hsel_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hready_in(hready_in),
	.hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
	.drive_running_in(drive_running_in), .fault_reset_in(fault_reset_in),
	.status_out(status_out), .filter_time_out(filter_time_out));

// >>> sim/fcl_feedback_tb.sv
// Self-checking bench for fcl_feedback: registers over AHB-Lite, counts, sources, fault.
// Assumes fcl_enc_model for both encoders and the bound checker.
`timescale 1ns/100ps
module fcl_feedback_tb;
	import fcl_pkg::*;
	logic clk_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic hsel_in = 1'b1;
	logic [31:0] haddr_in = 32'h0000_0000;
	logic [1:0] htrans_in = 2'h0;
	logic hwrite_in = 1'b0;
	logic [31:0] hwdata_in = 32'h0000_0000;
	logic [31:0] hrdata_out;
	logic hreadyout_out;
	logic hresp_out;
	fcl_enc_pins_t motor_enc;
	fcl_enc_pins_t ext_enc;
	logic gear_select_in = 1'b0;
	logic drive_running_in = 1'b0;
	logic fault_reset_in = 1'b0;
	fcl_status_t status_out;
	logic [31:0] position_feedback_out;
	logic [15:0] filter_time_out;
	// Index 0 is the motor encoder, 1 the external one
	logic [1:0] go = 2'h0;
	logic [1:0] rv = 2'h0;
	logic [1:0] zi = 2'h0;
	logic [1:0] busy;
	logic [15:0] steps = 16'h0000;
	logic [31:0] rd;
	int miscompares = 0;
	int n_tests = 0;
	initial
	forever #2.5 clk_in = ~clk_in;
	fcl_feedback i_fcl_feedback (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .hsel_in(hsel_in),
		.haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(3'h2),
		.hwdata_in(hwdata_in), .hready_in(hreadyout_out), .hrdata_out(hrdata_out),
		.hreadyout_out(hreadyout_out), .hresp_out(hresp_out), .motor_enc_in(motor_enc),
		.ext_enc_in(ext_enc), .gear_select_in(gear_select_in),
		.drive_running_in(drive_running_in), .fault_reset_in(fault_reset_in),
		.status_out(status_out), .position_feedback_out(position_feedback_out),
		.filter_time_out(filter_time_out));
	fcl_enc_model #(.DIV(1)) i_fcl_enc_model_m (.clk_in(clk_in), .go_in(go[0]), .rev_in(rv[0]),
		.steps_in(steps), .index_in(zi[0]), .pins_out(motor_enc), .busy_out(busy[0]));
	// Slower scale so both prompt and slow pulse trains are seen
	fcl_enc_model #(.DIV(3)) i_fcl_enc_model_e (.clk_in(clk_in), .go_in(go[1]), .rev_in(rv[1]),
		.steps_in(steps), .index_in(zi[1]), .pins_out(ext_enc), .busy_out(busy[1]));
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic lim(input int k, input int mx);
		if (k >= mx)
		begin
			miscompares++;
			$display("CHECK FAILED wait expected done seen timeout");
			summarize();
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_in);
	endtask
	task automatic wait_ready();
		int n;
		n = 0;
		do
		begin
			@(posedge clk_in);
			n++;
		end
		while (hreadyout_out !== 1'b1 && n < 64);
		lim(hreadyout_out === 1'b1 ? 0 : 64, 64);
	endtask
	task automatic xfer(input logic wr, input logic [13:0] idx, input logic [31:0] wd);
		haddr_in <= {16'h0000, idx, 2'h0};
		hwrite_in <= wr;
		htrans_in <= 2'h2;
		wait_ready();
		htrans_in <= 2'h0;
		hwdata_in <= wd;
		wait_ready();
		rd = hrdata_out;
	endtask
	task automatic move(input int m, input logic r, input logic [15:0] n);
		int k;
		go[m] <= 1'b1;
		rv[m] <= r;
		steps <= n;
		@(posedge clk_in);
		go[m] <= 1'b0;
		k = 0;
		do
		begin
			@(posedge clk_in);
			k++;
		end
		while (busy[m] === 1'b1 && k < 2000);
		lim(k, 2000);
		tick(8);
	endtask
	task automatic t_reset_values();
		logic [13:0] ri [16];
		logic [31:0] ev [16];
		ri = '{RI_FB_SRC, RI_EXT_DIR, RI_EXT_KIND, RI_SIG_TYPE, RI_PPR, RI_DEV_THR, RI_CLR_REVS,
			RI_FILT_TIME, RI_DEV_DISP, RI_INT_CNT, RI_EXT_CNT, RI_IDX_OFF, RI_PROBE_SRC,
			RI_THR_SCALE, RI_SPD_SRC, 14'h0f05};
		ev = '{16{32'h0000_0000}};
		ev[4] = RST_PPR;
		ev[5] = RST_DEV_THR;
		ev[6] = {25'h0, RST_CLR_REVS};
		for (int i = 0; i < 16; i++)
		begin
			xfer(1'b0, ri[i], 32'h0000_0000);
			chk("reset value", ev[i], rd);
		end
	endtask
	task automatic t_refused();
		logic [13:0] ri [7];
		logic [31:0] wv [7];
		logic [31:0] ev [7];
		ri = '{RI_FB_SRC, RI_CLR_REVS, RI_CLR_REVS, RI_CLR_REVS, RI_SIG_TYPE, RI_INT_CNT, RI_PPR};
		wv = '{32'h3, 32'h65, 32'h64, 32'h1, 32'h1, 32'h5, 32'h8000_0000};
		ev = '{32'h0, 32'h1, 32'h64, 32'h1, 32'h0, 32'h0, RST_PPR};
		for (int i = 0; i < 7; i++)
		begin
			xfer(1'b1, ri[i], wv[i]);
			xfer(1'b0, ri[i], 32'h0000_0000);
			chk("written value", ev[i], rd);
		end
	endtask
	task automatic t_counts();
		move(0, 1'b0, 16'h0028);
		xfer(1'b0, RI_INT_CNT, 32'h0000_0000);
		chk("internal count", 32'h0000_0028, rd);
		move(1, 1'b0, 16'h0028);
		xfer(1'b0, RI_EXT_CNT, 32'h0000_0000);
		chk("external count", 32'h0000_0028, rd);
		xfer(1'b0, RI_DEV_DISP, 32'h0000_0000);
		chk("deviation", 32'h28 - ((32'h28 * RST_PPR) >> MOTOR_RES_LOG2), rd);
		xfer(1'b1, RI_EXT_DIR, 32'h0000_0001);
		move(1, 1'b0, 16'h000a);
		xfer(1'b0, RI_EXT_CNT, 32'h0000_0000);
		chk("reversed count", 32'h0000_001e, rd);
		xfer(1'b1, RI_FB_SRC, 32'h0000_0001);
		tick(4);
		chk("selected feedback", 32'h0000_001e, position_feedback_out);
		xfer(1'b1, RI_DEV_THR, 32'h0000_0000);
		tick(4);
		xfer(1'b0, RI_DEV_DISP, 32'h0000_0000);
		chk("deviation held clear", 32'h0000_0000, rd);
	endtask
	task automatic t_source();
		logic [5:0] tv [4];
		// Row: source, gear input, then use_external, gear_ratio2, filter_active
		tv = '{6'h00, 6'h15, 6'h21, 6'h2f};
		xfer(1'b1, RI_FILT_TIME, 32'h0000_0005);
		for (int i = 0; i < 4; i++)
		begin
			gear_select_in <= tv[i][3];
			xfer(1'b1, RI_FB_SRC, {30'h0, tv[i][5:4]});
			tick(6);
			chk("source flags", {29'h0, tv[i][2:0]}, {29'h0, status_out.use_external,
				status_out.gear_ratio2, status_out.filter_active});
			chk("filter time", tv[i][0] ? 32'h5 : 32'h0, {16'h0, filter_time_out});
		end
	endtask
	task automatic t_modes();
		logic [13:0] mi [3];
		mi = '{RI_EXT_KIND, RI_THR_SCALE, RI_SPD_SRC};
		for (int i = 0; i < 3; i++)
		begin
			xfer(1'b1, mi[i], 32'h0000_0001);
			tick(4);
			chk("mode flags", {29'h0, 3'h4 >> i}, {29'h0, status_out.ext_absolute,
				status_out.thr_shared, status_out.speed_external});
			xfer(1'b1, mi[i], 32'h0000_0000);
		end
	endtask
	task automatic t_probe();
		int k;
		logic [4:0] pv [4];
		// Row: probe source, index check off, absolute kind, pulse external Z, expected index
		pv = '{5'h13, 5'h1a, 5'h16, 5'h01};
		for (int i = 0; i < 4; i++)
		begin
			xfer(1'b1, RI_PROBE_SRC, {31'h0, pv[i][4]});
			xfer(1'b1, RI_IDX_OFF, {31'h0, pv[i][3]});
			xfer(1'b1, RI_EXT_KIND, {31'h0, pv[i][2]});
			zi[pv[i][1]] <= 1'b1;
			tick(2);
			zi <= 2'h0;
			k = 0;
			// A missing pulse runs the full window and is then judged
			while (status_out.probe_index !== 1'b1 && k < 16)
			begin
				@(negedge clk_in);
				k++;
			end
			chk("probe index", {31'h0, pv[i][0]}, {31'h0, status_out.probe_index});
			@(posedge clk_in);
		end
	endtask
	task automatic t_fault();
		xfer(1'b1, RI_DEV_THR, 32'h0000_000a);
		xfer(1'b1, RI_CLR_REVS, 32'h0000_0000);
		xfer(1'b1, RI_EXT_DIR, 32'h0000_0000);
		drive_running_in <= 1'b1;
		move(1, 1'b0, 16'h0014);
		chk("fault raised", 32'h1, {31'h0, status_out.fault});
		fault_reset_in <= 1'b1;
		tick(3);
		fault_reset_in <= 1'b0;
		tick(3);
		chk("fault kept while running", 32'h1, {31'h0, status_out.fault});
		drive_running_in <= 1'b0;
		tick(2);
		fault_reset_in <= 1'b1;
		tick(1);
		fault_reset_in <= 1'b0;
		tick(4);
		chk("fault cleared", 32'h0, {31'h0, status_out.fault});
	endtask
	initial
	begin
		repeat (4) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		@(posedge clk_in);
		t_reset_values();
		t_refused();
		t_counts();
		t_source();
		t_modes();
		t_probe();
		t_fault();
		summarize();
	end
endmodule
